/* design/storage_cmd_consts.vh */
// Constants for the task-file command engine: register indices,
// opcodes, error codes, sizes and geometry.
// Assumes inclusion by bare name from files under design/ and tb/.
`ifndef STORAGE_CMD_CONSTS_VH
`define STORAGE_CMD_CONSTS_VH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------
`define IDX_DATA        4'h0
`define IDX_FEATURE     4'h1
`define IDX_COUNT       4'h2
`define IDX_SECTOR      4'h3
`define IDX_CYL_LO      4'h4
`define IDX_CYL_HI      4'h5
`define IDX_DRVHEAD     4'h6
`define IDX_COMMAND     4'h7
`define IDX_NONE        4'hF
`define ADDR_TOP        12'h01C

// ----------------------------------------------------------------
// Error register and drive/head register bits.
// ----------------------------------------------------------------
`define ERR_ABORT       8'h04
`define ERR_MEDIA       8'h40
`define DH_LBA          6

// ----------------------------------------------------------------
// Opcodes.
// ----------------------------------------------------------------
`define OP_READ_A       8'h20
`define OP_READ_B       8'h21
`define OP_VERIFY_A     8'h40
`define OP_VERIFY_B     8'h41
`define OP_RECAL_HI     4'h1
`define OP_SENSE        8'h03
`define OP_PW_DISABLE   8'hF6
`define OP_ERASE_PREP   8'hF3
`define OP_ERASE_UNIT   8'hF4

// ----------------------------------------------------------------
// Extended error codes reported by request sense.
// ----------------------------------------------------------------
`define XE_NONE         8'h00
`define XE_INVALID_CMD  8'h20
`define XE_UNCORR_ECC   8'h11
`define XE_ABORTED      8'h1F

// ----------------------------------------------------------------
// Sizes, geometry and AXI answers.
// ----------------------------------------------------------------
`define SECTOR_WORDS    9'h100
`define PW_FIRST_WORD   8'h01
`define PW_LAST_WORD    8'h10
`define GEOM_SPT        8'h20
`define GEOM_LAST_HEAD  4'hF
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11

`endif

/* design/storage_cmd_engine.v */
// Task-file command engine: sector read and verify, recalibrate,
// request sense, password disable and erase, over AXI4-Lite.
// Assumes media engine and password store on the same clock.
//
// Behaviour
// RL1: Opcodes 20h/21h read 1..256 sectors, zero means 256.
// RL2: Count and start address come from task file.
// RL3: Per sector: busy, fill buffer, request, unbusy, interrupt.
// RL4: Host drains 512 bytes before next sector fetch.
// RL5: Success leaves address of last sector read.
// RL6: Error stops read, address and data kept.
// RL7: Opcodes 40h/41h verify without data request.
// RL8: Verify sets busy, then clears it with interrupt.
// RL9: Verify success leaves last verified address.
// RL10: Verify error keeps address, count holds remaining.
// RL11: Any 1Xh opcode completes as a no-operation.
// RL12: Opcode 03h loads extended code into error register.
// RL13: General outcome codes as listed.
// RL14: Media error codes as listed.
// RL15: Voltage, self test, format codes as listed.
// RL16: Opcode F6h takes one sector from host first.
// RL17: Sector word 0 bit 0 selects password.
// RL18: Matching password turns lock mode off.
// RL19: Disable leaves stored master password intact.
// RL20: Host issues F3h directly before erase unit.
// RL21: Erase unit aborts without preceding erase prepare.
// RL22: Erase unit password mismatch aborts, lock unchanged.
// RL23: Disable mismatch aborts, lock unchanged.
// RL24: Other accepted commands clear erase-prepare flag.
`default_nettype none
`include "storage_cmd_consts.vh"

module storage_cmd_engine (
   // Clock and reset.
   input  wire         CLK_I,
   input  wire         RST_I,
   // AXI4-Lite write channels.
   input  wire [11:0]  AWADDR_I,
   input  wire         AWVALID_I,
   output wire         AWREADY_O,
   input  wire [31:0]  WDATA_I,
   input  wire [3:0]   WSTRB_I,
   input  wire         WVALID_I,
   output wire         WREADY_O,
   output wire [1:0]   BRESP_O,
   output wire         BVALID_O,
   input  wire         BREADY_I,
   // AXI4-Lite read channels.
   input  wire [11:0]  ARADDR_I,
   input  wire         ARVALID_I,
   output wire         ARREADY_O,
   output wire [31:0]  RDATA_O,
   output wire [1:0]   RRESP_O,
   output wire         RVALID_O,
   input  wire         RREADY_I,
   // Media engine.
   output wire         MED_REQ_O,
   output wire         MED_VERIFY_O,
   output wire         MED_LBA_MODE_O,
   output wire [27:0]  MED_ADDR_O,
   input  wire         MED_VALID_I,
   input  wire [15:0]  MED_WORD_I,
   input  wire         MED_DONE_I,
   input  wire         MED_ERR_I,
   input  wire [7:0]   MED_CODE_I,
   // Password store and lock.
   input  wire [255:0] USER_PW_I,
   input  wire [255:0] MASTER_PW_I,
   input  wire         LOCK_AT_RESET_I,
   output wire         LOCK_O,
   output wire         ERASE_GO_O,
   // Host interrupt request.
   output wire         INTRQ_O
);

   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_FETCH = 3'd1;
   localparam [2:0] ST_XFER  = 3'd2;
   localparam [2:0] ST_PWIN  = 3'd3;
   localparam [2:0] ST_PWCHK = 3'd4;

   // Address decode, used by both the write and the read channel.
   function [3:0] reg_index;
      input [11:0] a;
      begin
         if (a[1:0] != 2'b00 || a > `ADDR_TOP) begin
            reg_index = `IDX_NONE;
         end else begin
            reg_index = {1'b0, a[4:2]};
         end
      end
   endfunction

   // One 16-bit word of a stored password, k counting from zero.
   function [15:0] pw_word;
      input [255:0] pw;
      input [3:0]   k;
      reg   [255:0] sh;
      begin
         sh      = pw >> {k, 4'h0};
         pw_word = sh[15:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   reg  [2:0]  state_r;
   reg  [7:0]  count_r;
   reg  [7:0]  sector_r;
   reg  [7:0]  cyl_lo_r;
   reg  [7:0]  cyl_hi_r;
   reg  [7:0]  drvhead_r;
   reg  [7:0]  error_r;
   reg  [7:0]  sense_r;
   reg         err_flag_r;
   reg  [8:0]  remain_r;
   reg  [8:0]  ptr_r;
   reg         verify_r;
   reg         erase_cmd_r;
   reg         last_err_r;
   reg         prep_r;
   reg         sel_master_r;
   reg         mismatch_r;
   reg         lock_r;
   reg         lock_taken_r;
   reg         erase_go_r;
   reg         intrq_r;
   reg  [15:0] buf_mem [0:255];
   reg  [15:0] buf_rd_r;

   reg         aw_held_r;
   reg  [3:0]  aw_idx_r;
   reg         w_held_r;
   reg  [31:0] wdata_r;
   reg  [3:0]  wstrb_r;
   reg         bvalid_r;
   reg  [1:0]  bresp_r;
   reg         rvalid_r;
   reg  [31:0] rdata_r;
   reg  [1:0]  rresp_r;

   wire        wr_go   = aw_held_r & w_held_r & ~bvalid_r;
   wire        rd_go   = ARVALID_I & ~rvalid_r;
   wire [3:0]  rd_idx  = reg_index(ARADDR_I);
   wire        busy    = (state_r == ST_FETCH) || (state_r == ST_PWCHK);
   wire        data_request_flag     = (state_r == ST_XFER) || (state_r == ST_PWIN);
   wire        cmd_go  = wr_go & wstrb_r[0] & (aw_idx_r == `IDX_COMMAND)
                         & (state_r == ST_IDLE);
   wire        tf_wr   = wr_go & wstrb_r[0] & (state_r == ST_IDLE);
   wire        pop     = rd_go & (rd_idx == `IDX_DATA)
                         & (state_r == ST_XFER);
   wire        push    = wr_go & (aw_idx_r == `IDX_DATA)
                         & (state_r == ST_PWIN);
   wire        linear_block_addressing     = drvhead_r[`DH_LBA];
   wire [7:0]  opcode  = wdata_r[7:0];
   wire [7:0]  status;
   wire [3:0]  pw_k    = ptr_r[3:0] - 4'h1;
   wire [15:0] pw_ref  = sel_master_r ? pw_word(MASTER_PW_I, pw_k)
                                      : pw_word(USER_PW_I, pw_k);

   assign status = {busy, ~busy, 1'b0, ~busy, data_request_flag, 2'b00, err_flag_r};

   // ----------------------------------------------------------------
   // AXI4-Lite channel handshakes.
   // ----------------------------------------------------------------
   // Address and data are parked separately so either may come first.
   assign AWREADY_O = ~aw_held_r;
   assign WREADY_O  = ~w_held_r;
   assign BVALID_O  = bvalid_r;
   assign BRESP_O   = bresp_r;
   assign ARREADY_O = ~rvalid_r;
   assign RVALID_O  = rvalid_r;
   assign RDATA_O   = rdata_r;
   assign RRESP_O   = rresp_r;

   // Write channel holding registers and response.
   always @(posedge CLK_I) begin
      if (RST_I) begin
         aw_held_r <= 1'b0;
         aw_idx_r  <= `IDX_NONE;
         w_held_r  <= 1'b0;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
      end else begin
         if (AWVALID_I && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_idx_r  <= reg_index(AWADDR_I);
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (WVALID_I && !w_held_r) begin
            w_held_r <= 1'b1;
            wdata_r  <= WDATA_I;
            wstrb_r  <= WSTRB_I;
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (aw_idx_r == `IDX_NONE) ? `RESP_DECERR : `RESP_OKAY;
         end else if (BREADY_I) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel; the answer is registered one cycle after the address.
   always @(posedge CLK_I) begin
      if (RST_I) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rresp_r  <= `RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
         if (rd_idx == `IDX_DATA) begin
            rdata_r <= {16'h0000, buf_rd_r};
         end else if (rd_idx == `IDX_FEATURE) begin
            rdata_r <= {24'h000000, error_r};
         end else if (rd_idx == `IDX_COUNT) begin
            rdata_r <= {24'h000000, count_r};
         end else if (rd_idx == `IDX_SECTOR) begin
            rdata_r <= {24'h000000, sector_r};
         end else if (rd_idx == `IDX_CYL_LO) begin
            rdata_r <= {24'h000000, cyl_lo_r};
         end else if (rd_idx == `IDX_CYL_HI) begin
            rdata_r <= {24'h000000, cyl_hi_r};
         end else if (rd_idx == `IDX_DRVHEAD) begin
            rdata_r <= {24'h000000, drvhead_r};
         end else if (rd_idx == `IDX_COMMAND) begin
            rdata_r <= {24'h000000, status};
         end else begin
            rresp_r <= `RESP_DECERR;
         end
      end else if (RREADY_I) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Sector buffer.
   // ----------------------------------------------------------------
   // Media or host fills it; the next read word is prefetched.
   always @(posedge CLK_I) begin
      if (state_r == ST_FETCH && MED_VALID_I && !verify_r) begin
         buf_mem[ptr_r[7:0]] <= MED_WORD_I; // see RL3
      end else if (push) begin
         buf_mem[ptr_r[7:0]] <= wdata_r[15:0]; // see RL16
      end
      buf_rd_r <= buf_mem[pop ? ptr_r[7:0] + 8'h01 : ptr_r[7:0]];
   end

   // ----------------------------------------------------------------
   // Media request and address.
   // ----------------------------------------------------------------
   assign MED_REQ_O      = (state_r == ST_FETCH);
   assign MED_VERIFY_O   = verify_r; // see RL7
   assign MED_LBA_MODE_O = linear_block_addressing;
   assign MED_ADDR_O     = {drvhead_r[3:0], cyl_hi_r, cyl_lo_r, sector_r};
   assign LOCK_O         = lock_r;
   assign ERASE_GO_O     = erase_go_r;
   assign INTRQ_O        = intrq_r;

   // Next sector address, linear or cylinder/head/sector.
   reg [27:0] next_addr;
   always @* begin
      next_addr = {drvhead_r[3:0], cyl_hi_r, cyl_lo_r, sector_r};
      if (linear_block_addressing) begin
         next_addr = next_addr + 28'h0000001;
      end else if (sector_r != `GEOM_SPT) begin
         next_addr[7:0] = sector_r + 8'h01;
      end else begin
         next_addr[7:0] = 8'h01;
         if (drvhead_r[3:0] != `GEOM_LAST_HEAD) begin
            next_addr[27:24] = drvhead_r[3:0] + 4'h1;
         end else begin
            next_addr[27:24] = 4'h0;
            next_addr[23:8]  = {cyl_hi_r, cyl_lo_r} + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Command state machine and task file.
   // ----------------------------------------------------------------
   // Completion raises the interrupt and records the extended code;
   // a status read clears it, but a same-cycle event wins.
   always @(posedge CLK_I) begin
      if (RST_I) begin
         state_r      <= ST_IDLE;
         count_r      <= 8'h01;
         sector_r     <= 8'h01;
         cyl_lo_r     <= 8'h00;
         cyl_hi_r     <= 8'h00;
         drvhead_r    <= 8'h00;
         error_r      <= 8'h00;
         sense_r      <= `XE_NONE;
         err_flag_r   <= 1'b0;
         remain_r     <= 9'h000;
         ptr_r        <= 9'h000;
         verify_r     <= 1'b0;
         erase_cmd_r  <= 1'b0;
         last_err_r   <= 1'b0;
         prep_r       <= 1'b0;
         sel_master_r <= 1'b0;
         mismatch_r   <= 1'b0;
         lock_r       <= 1'b0;
         lock_taken_r <= 1'b0;
         erase_go_r   <= 1'b0;
         intrq_r      <= 1'b0;
      end else begin
         erase_go_r <= 1'b0;
         if (rd_go && rd_idx == `IDX_COMMAND) begin
            intrq_r <= 1'b0;
         end
         // Lock level caught once, one edge after reset release.
         if (!lock_taken_r) begin
            lock_taken_r <= 1'b1;
            lock_r       <= LOCK_AT_RESET_I;
         end
         // Task file writes are ignored while a command runs.
         if (tf_wr) begin
            if (aw_idx_r == `IDX_COUNT)   count_r   <= wdata_r[7:0]; // see RL2
            if (aw_idx_r == `IDX_SECTOR)  sector_r  <= wdata_r[7:0]; // see RL2
            if (aw_idx_r == `IDX_CYL_LO)  cyl_lo_r  <= wdata_r[7:0];
            if (aw_idx_r == `IDX_CYL_HI)  cyl_hi_r  <= wdata_r[7:0];
            if (aw_idx_r == `IDX_DRVHEAD) drvhead_r <= wdata_r[7:0];
         end
         case (state_r)
            ST_IDLE: begin
               if (cmd_go) begin
                  prep_r      <= 1'b0; // see RL24
                  err_flag_r  <= 1'b0;
                  error_r     <= 8'h00;
                  ptr_r       <= 9'h000;
                  mismatch_r  <= 1'b0;
                  erase_cmd_r <= (opcode == `OP_ERASE_UNIT);
                  verify_r    <= (opcode == `OP_VERIFY_A) ||
                                 (opcode == `OP_VERIFY_B);
                  // Zero in the count register asks for 256 sectors.
                  remain_r    <= (count_r == 8'h00) ? `SECTOR_WORDS
                                 : {1'b0, count_r}; // see RL1
                  if (opcode == `OP_READ_A || opcode == `OP_READ_B ||
                      opcode == `OP_VERIFY_A || opcode == `OP_VERIFY_B) begin
                     state_r <= ST_FETCH; // see RL1, RL3, RL8
                  end else if (opcode[7:4] == `OP_RECAL_HI) begin
                     intrq_r <= 1'b1; // see RL11
                     sense_r <= `XE_NONE;
                  end else if (opcode == `OP_SENSE) begin
                     error_r <= sense_r; // see RL12
                     intrq_r <= 1'b1;
                  end else if (opcode == `OP_ERASE_PREP) begin
                     prep_r  <= 1'b1; // see RL24
                     intrq_r <= 1'b1;
                     sense_r <= `XE_NONE;
                  end else if (opcode == `OP_PW_DISABLE ||
                               (opcode == `OP_ERASE_UNIT && prep_r)) begin
                     state_r <= ST_PWIN; // see RL16, RL21
                  end else if (opcode == `OP_ERASE_UNIT) begin
                     err_flag_r <= 1'b1; // see RL21
                     error_r    <= `ERR_ABORT;
                     sense_r    <= `XE_ABORTED;
                     intrq_r    <= 1'b1;
                  end else begin
                     err_flag_r <= 1'b1; // see RL13
                     error_r    <= `ERR_ABORT;
                     sense_r    <= `XE_INVALID_CMD;
                     intrq_r    <= 1'b1;
                  end
               end
            end
            ST_FETCH: begin
               if (MED_VALID_I && !verify_r) begin
                  ptr_r <= ptr_r + 9'h001;
               end
               if (MED_DONE_I) begin
                  ptr_r <= 9'h000;
                  if (MED_ERR_I) begin
                     // Stop at the failing sector; address stays on it.
                     err_flag_r <= 1'b1; // see RL6, RL10
                     error_r    <= `ERR_MEDIA;
                     sense_r    <= MED_CODE_I; // see RL14, RL15
                     count_r    <= remain_r[7:0]; // see RL10
                     intrq_r    <= 1'b1;
                     last_err_r <= 1'b1;
                     state_r    <= verify_r ? ST_IDLE : ST_XFER; // see RL6
                  end else if (verify_r) begin
                     if (remain_r == 9'h001) begin
                        count_r <= 8'h00;
                        sense_r <= `XE_NONE;
                        intrq_r <= 1'b1; // see RL8, RL9
                        state_r <= ST_IDLE;
                     end else begin
                        remain_r <= remain_r - 9'h001;
                        {drvhead_r[3:0], cyl_hi_r, cyl_lo_r, sector_r}
                           <= next_addr;
                     end
                  end else begin
                     // Sector ready: hand it to the host.
                     last_err_r <= 1'b0;
                     intrq_r    <= 1'b1; // see RL3
                     state_r    <= ST_XFER;
                  end
               end
            end
            ST_XFER: begin
               // The next fetch waits for a full 256-word drain.
               if (pop) begin
                  if (ptr_r == `SECTOR_WORDS - 9'h001) begin
                     ptr_r <= 9'h000; // see RL4
                     if (last_err_r || remain_r == 9'h001) begin
                        if (!last_err_r) begin
                           count_r <= 8'h00;
                           sense_r <= `XE_NONE; // see RL5
                        end
                        state_r <= ST_IDLE;
                     end else begin
                        remain_r <= remain_r - 9'h001;
                        count_r  <= remain_r[7:0] - 8'h01;
                        {drvhead_r[3:0], cyl_hi_r, cyl_lo_r, sector_r}
                           <= next_addr; // see RL3
                        state_r  <= ST_FETCH;
                     end
                  end else begin
                     ptr_r <= ptr_r + 9'h001;
                  end
               end
            end
            ST_PWIN: begin
               // Word 0 bit 0 picks the password compared by words 1..16.
               if (push) begin
                  if (ptr_r == 9'h000) begin
                     sel_master_r <= wdata_r[0]; // see RL17
                  end else if (ptr_r[7:0] >= `PW_FIRST_WORD &&
                               ptr_r[7:0] <= `PW_LAST_WORD &&
                               wdata_r[15:0] != pw_ref) begin
                     mismatch_r <= 1'b1;
                  end
                  if (ptr_r == `SECTOR_WORDS - 9'h001) begin
                     state_r <= ST_PWCHK;
                  end
                  ptr_r <= ptr_r + 9'h001;
               end
            end
            ST_PWCHK: begin
               // Stored passwords are inputs and never written here.
               ptr_r   <= 9'h000;
               intrq_r <= 1'b1;
               state_r <= ST_IDLE;
               if (mismatch_r) begin
                  err_flag_r <= 1'b1; // see RL22, RL23
                  error_r    <= `ERR_ABORT;
                  sense_r    <= `XE_ABORTED;
               end else begin
                  lock_r     <= 1'b0; // see RL18, RL19
                  erase_go_r <= erase_cmd_r;
                  sense_r    <= `XE_NONE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // storage_cmd_engine
`default_nettype wire

/* tb/media_model.sv */
// Media engine model: one sector of 256 words, then a done pulse.
// Assumes the engine holds its request until it has seen done.
`default_nettype none
`include "storage_cmd_consts.vh"
module media_model (
   input  wire logic        CLK_I, RST_I, MED_REQ_O, MED_VERIFY_O,
   input  wire logic [27:0] MED_ADDR_O,
   input  wire logic [7:0]  fail_sec_i,
   output var  logic        MED_VALID_I, MED_DONE_I, MED_ERR_I,
   output var  logic [15:0] MED_WORD_I,
   output var  logic [7:0]  MED_CODE_I
);
   logic [9:0] cnt_r = 10'h0;
   initial {MED_VALID_I, MED_DONE_I, MED_ERR_I, MED_WORD_I, MED_CODE_I} = '0;
   // A word every other cycle; between words the bus shows the inverse.
   always @(posedge CLK_I) begin
      MED_VALID_I <= 1'b0;
      MED_DONE_I  <= 1'b0;
      MED_WORD_I  <= ~MED_WORD_I;
      cnt_r <= (RST_I || !MED_REQ_O || MED_DONE_I) ? 10'h0 : cnt_r + 10'h1;
      if (MED_REQ_O && !MED_VERIFY_O && cnt_r[0] && !cnt_r[9]) begin
         MED_VALID_I <= 1'b1;
         MED_WORD_I  <= {MED_ADDR_O[7:0], cnt_r[8:1]};
      end
      if (cnt_r == 10'h208) begin
         MED_DONE_I <= 1'b1;
         MED_ERR_I  <= MED_ADDR_O[7:0] == fail_sec_i;
         MED_CODE_I <= `XE_UNCORR_ECC;
      end
   end
endmodule // media_model
`default_nettype wire

/* tb/storage_card_read_verify_security_cmds_tb.sv */
// Bench: AXI4-Lite host tasks, media model and a read scoreboard.
// Assumes the engine, its header and the bound checker are compiled.
`default_nettype none
`include "storage_cmd_consts.vh"
module storage_card_read_verify_security_cmds_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
   logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, MED_REQ_O;
   logic MED_VERIFY_O, MED_LBA_MODE_O, MED_VALID_I, MED_DONE_I, MED_ERR_I;
   logic LOCK_O, ERASE_GO_O, INTRQ_O, LOCK_AT_RESET_I;
   logic [11:0]  AWADDR_I, ARADDR_I;
   logic [31:0]  WDATA_I, RDATA_O;
   logic [1:0]   BRESP_O, RRESP_O;
   logic [3:0]   WSTRB_I;
   logic [27:0]  MED_ADDR_O;
   logic [15:0]  MED_WORD_I, lf;
   logic [7:0]   MED_CODE_I, fail_sec_i;
   logic [255:0] USER_PW_I, MASTER_PW_I, pw;
   logic [33:0]  exq[$];
   int           mismatches, check_count, go, k, m;
   storage_cmd_engine i_dut (.*);
   media_model i_med (.*);
   assign MASTER_PW_I = ~USER_PW_I;
   initial begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end
   function automatic logic [15:0] nxt(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %0t saw %h want %h", $time, s, e);
      end
   endtask
   task test_done;
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task bail;
      mismatches++;
      test_done;
   endtask
   // One AXI transfer; a read queues its expected answer.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      logic p, h, f;
      int   t;
      @(posedge CLK_I);
      f = 1'b0;
      if (w) begin
         {AWADDR_I, WDATA_I} <= {6'h0, a, 2'h0, d};
         {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
      end else begin
         ARADDR_I <= {6'h0, a, 2'h0};
         {ARVALID_I, RREADY_I} <= 2'h3;
         exq.push_back(a > 7 ? 34'h300000000 : {2'h0, d});
      end
      for (t = 0; t < 99 && !f; t++) begin
         @(negedge CLK_I);
         p = w ? AWREADY_O : ARREADY_O;
         h = WREADY_O;
         f = w ? BVALID_O : RVALID_O;
         if (w && f) chk(BRESP_O, a > 7 ? 2'h3 : 2'h0);
         @(posedge CLK_I);
         if (p) {AWVALID_I, ARVALID_I} <= 2'h0;
         if (h) WVALID_I <= 1'b0;
      end
      {BREADY_I, RREADY_I} <= 2'h0;
      if (!f) bail;
   endtask
   task automatic wirq;
      int t;
      for (t = 0; t < 3000 && INTRQ_O !== 1'b1; t++) @(negedge CLK_I);
      if (INTRQ_O !== 1'b1) bail;
   endtask
   // Scoreboard: each read answer meets the oldest note.
   always @(negedge CLK_I) begin
      if (RVALID_O && RREADY_I) chk({RRESP_O, RDATA_O}, exq.pop_front());
      if (ERASE_GO_O) go++;
   end
   initial begin
      {RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 6'h20;
      {AWADDR_I, ARADDR_I, WDATA_I} = '0;
      {WSTRB_I, LOCK_AT_RESET_I, fail_sec_i, lf} = {4'hF, 9'h1FF, 16'd10091};
      for (k = 0; k < 16; k++) begin
         lf = nxt(lf);
         USER_PW_I[k*16 +: 16] = lf;
      end
      repeat (8) @(posedge CLK_I);
      RST_I <= 1'b0;
      bus(0, 2, 1); bus(0, 3, 1); bus(0, 7, 'h50);
      bus(0, 8, 0); bus(1, 8, 0); chk(LOCK_O, 1'b1);
      lf = nxt(lf);
      bus(1, 4, lf[7:0]); bus(1, 3, 1); bus(1, 2, 2); bus(1, 7, `OP_READ_A);
      for (m = 1; m < 3; m++) begin
         wirq;
         bus(0, 7, 'h58);
         for (k = 0; k < 256; k++) bus(0, 0, {m[7:0], k[7:0]});
      end
      bus(0, 7, 'h50); bus(0, 3, 2); bus(0, 2, 0); bus(0, 4, lf[7:0]);
      fail_sec_i <= 8'h02;
      bus(1, 3, 1); bus(1, 2, 3); bus(1, 7, `OP_VERIFY_B); wirq;
      bus(0, 7, 'h51); bus(0, 2, 2); bus(0, 3, 2);
      bus(0, 1, `ERR_MEDIA); bus(1, 7, `OP_SENSE);
      bus(0, 1, `XE_UNCORR_ECC);
      for (k = 0; k < 16; k += 7) begin
         bus(1, 7, 8'h10 | k[7:0]); wirq; bus(0, 7, 'h50);
      end
      bus(1, 7, `OP_SENSE); bus(0, 1, `XE_NONE);
      bus(1, 7, `OP_ERASE_UNIT); bus(0, 7, 'h51); bus(0, 1, `ERR_ABORT);
      for (m = 0; m < 3; m++) begin
         pw = m == 2 ? MASTER_PW_I : USER_PW_I;
         if (m == 2) bus(1, 7, `OP_ERASE_PREP);
         bus(1, 7, m == 2 ? `OP_ERASE_UNIT : `OP_PW_DISABLE);
         bus(0, 7, 'h58);
         for (k = 0; k < 256; k++)
            bus(1, 0, k == 0 ? {31'h0, m != 1} : k > 16 ? 32'h0
                : {16'h0, pw[k*16-16 +: 16]});
         wirq;
         bus(0, 7, m == 0 ? 'h51 : 'h50);
         chk(LOCK_O, m == 0);
         chk(go, m == 2);
      end
      test_done;
   end
endmodule // storage_card_read_verify_security_cmds_tb
`default_nettype wire

/* tb/storage_cmd_asserts.sv */
// Checker for the command engine ports: bus answers and media steps.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module storage_cmd_asserts (
   input wire logic        CLK_I, RST_I, AWVALID_I, AWREADY_O, WVALID_I,
   input wire logic        WREADY_O, BVALID_O, BREADY_I, ARVALID_I,
   input wire logic        ARREADY_O, RVALID_O, RREADY_I, MED_REQ_O,
   input wire logic        MED_VERIFY_O, MED_DONE_I, MED_ERR_I, INTRQ_O,
   input wire logic        ERASE_GO_O,
   input wire logic [31:0] RDATA_O,
   input wire logic [27:0] MED_ADDR_O
);
   // -------
   // Timing relations, all on the one clock.
   // -------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   property p_rhold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data lost");
   property p_bhold; BVALID_O && !BREADY_I |=> BVALID_O; endproperty
   a_bhold: assert property (p_bhold) else $error("write answer lost");
   property p_wlat; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
      && !BVALID_O |-> ##2 BVALID_O; endproperty
   a_wlat: assert property (p_wlat) else $error("late write answer");
   property p_ar; ARVALID_I && ARREADY_O |=> RVALID_O; endproperty
   a_ar: assert property (p_ar) else $error("no read answer");
   // A fetched read sector ends busy and raises the interrupt at once.
   property p_rdirq; MED_REQ_O && !MED_VERIFY_O && MED_DONE_I
      |=> INTRQ_O && !MED_REQ_O; endproperty
   a_rdirq: assert property (p_rdirq) else $error("no sector irq");
   property p_stop; MED_REQ_O && MED_DONE_I && MED_ERR_I |=> !MED_REQ_O;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_addr; $rose(MED_REQ_O) |-> ##2 $stable(MED_ADDR_O) [*6];
   endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_go; ERASE_GO_O |=> !ERASE_GO_O; endproperty
   a_go: assert property (p_go) else $error("long erase pulse");
endmodule // storage_cmd_asserts
bind storage_cmd_engine storage_cmd_asserts i_chk (.*);
`default_nettype wire
